// ### logic/mdc_pkg.sv
// Shared constants, request and answer carriers for the multiply/divide coprocessor
package mdc_pkg;

  localparam int MDC_DATA_W = 16;
  localparam int MDC_RES_W = 32;
  localparam int MDC_MODE_W = 7;

  // Mode register layout
  localparam int MDC_OUTM_LSB = 4;
  localparam int MDC_OUTM_MSB = 6;
  localparam int MDC_OP_LSB = 0;
  localparam int MDC_OP_MSB = 3;
  localparam logic [6:0] MDC_MODE_RESET = 7'h00;

  // Operation codes
  localparam logic [3:0] MDC_OP_CLEAR = 4'h0;
  localparam logic [3:0] MDC_OP_LOAD16 = 4'h1;
  localparam logic [3:0] MDC_OP_LOAD32 = 4'h2;
  localparam logic [3:0] MDC_OP_READ = 4'h3;
  localparam logic [3:0] MDC_OP_MULU = 4'h4;
  localparam logic [3:0] MDC_OP_MULS = 4'h5;
  localparam logic [3:0] MDC_OP_MACS = 4'h7;
  localparam logic [3:0] MDC_OP_DIVU = 4'h8;
  localparam logic [3:0] MDC_OP_DIVS = 4'h9;

  // Output mode codes
  localparam logic [2:0] MDC_OUTM_LOW = 3'h0;
  localparam logic [2:0] MDC_OUTM_HIGH = 3'h1;

  // Flag bit positions, order C V Z N
  localparam int MDC_FLAG_V = 2;
  localparam logic [3:0] MDC_FLAGS_CLEAR = 4'h0;

  // Divider timing
  localparam logic [4:0] MDC_DIV_STEPS = 5'h10;
  localparam int MDC_DIV_MIN_CYC = 17;
  localparam int MDC_DIV_MAX_CYC = 20;

  typedef enum logic [1:0] {
    MDC_REQ_MODE,
    MDC_REQ_OPERAND,
    MDC_REQ_INIT
  } mdc_req_kind_t;

  typedef struct packed {
    mdc_req_kind_t kind;
    logic [15:0] data_a;
    logic [15:0] data_b;
  } mdc_req_t;

  typedef struct packed {
    logic [15:0] data;
    logic [3:0] flags;
  } mdc_rsp_t;

  function automatic logic [15:0] mdc_pick_half(input logic [31:0] res, input logic [2:0] outm);
    return (outm == MDC_OUTM_HIGH) ? res[31:16] : res[15:0];
  endfunction : mdc_pick_half

endpackage : mdc_pkg

// ### logic/mdc_mac_unit.sv
// Single-cycle 16x16 multiplier with 32-bit signed accumulate
`timescale 1ns/1ps
module mdc_mac_unit
  import mdc_pkg::*;
(
  input wire logic [15:0] i_op_a,
  input wire logic [15:0] i_op_b,
  input wire logic i_signed,
  input wire logic [31:0] i_acc,
  output logic [31:0] o_product,
  output logic [31:0] o_sum,
  output logic o_overflow
);

  wire [31:0] prod_u = 32'(i_op_a) * 32'(i_op_b);
  wire signed [31:0] prod_s = 32'($signed(i_op_a)) * 32'($signed(i_op_b));

  assign o_product = i_signed ? prod_s : prod_u;
  assign o_sum = i_acc + prod_s;
  // Overflow only when both addends share a sign and the sum flips it
  assign o_overflow = (i_acc[31] == prod_s[31]) && (o_sum[31] != i_acc[31]);

endmodule : mdc_mac_unit

// ### logic/mdc_divider.sv
// Sequential 16/16 restoring divider, unsigned and signed
`timescale 1ns/1ps
module mdc_divider
  import mdc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_start,
  input wire logic i_signed,
  input wire logic [15:0] i_dividend,
  input wire logic [15:0] i_divisor,
  output logic o_done,
  output logic [15:0] o_quotient,
  output logic [15:0] o_residue
);

  typedef enum logic [1:0] {DV_IDLE, DV_RUN, DV_FIX, DV_DONE} mdc_div_state_t;

  mdc_div_state_t state;
  logic [15:0] quo;
  logic [15:0] rem;
  logic [15:0] dvs;
  logic [4:0] cnt;
  logic neg_q;
  logic neg_r;
  logic fix;

  wire dd_neg = i_signed && i_dividend[15];
  wire dv_neg = i_signed && i_divisor[15];
  wire [15:0] dd_mag = dd_neg ? 16'(-i_dividend) : i_dividend;
  wire [15:0] dv_mag = dv_neg ? 16'(-i_divisor) : i_divisor;
  wire [16:0] shifted = {rem, quo[15]};
  wire [17:0] diff = {1'b0, shifted} - {2'b00, dvs};
  wire fits = !diff[17];

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state <= DV_IDLE;
      quo <= 16'h0000;
      rem <= 16'h0000;
      dvs <= 16'h0000;
      cnt <= 5'h00;
      neg_q <= 1'b0;
      neg_r <= 1'b0;
      fix <= 1'b0;
    end else begin
      unique case (state)
        DV_IDLE: begin
          if (i_start) begin
            quo <= dd_mag;
            rem <= 16'h0000;
            dvs <= dv_mag;
            cnt <= MDC_DIV_STEPS;
            neg_q <= dd_neg ^ dv_neg;
            neg_r <= dd_neg;
            fix <= i_signed;
            state <= DV_RUN;
          end
        end
        DV_RUN: begin
          rem <= fits ? diff[15:0] : shifted[15:0];
          quo <= {quo[14:0], fits};
          cnt <= cnt - 5'h01;
          // Signed operands cost one extra cycle for the sign fix
          if (cnt == 5'h01) begin
            state <= fix ? DV_FIX : DV_DONE;
          end
        end
        DV_FIX: begin
          if (neg_q) begin
            quo <= 16'(-quo);
          end
          if (neg_r) begin
            rem <= 16'(-rem);
          end
          state <= DV_DONE;
        end
        DV_DONE: begin
          state <= DV_IDLE;
        end
      endcase
    end
  end

  assign o_done = (state == DV_DONE);
  assign o_quotient = quo;
  assign o_residue = rem;

endmodule : mdc_divider

// ### logic/mdc_top.sv
// Multiply / multiply-accumulate / divide coprocessor seen from the CPU core
//
// How it works
// - Op 0x4 multiplies unsigned, 0x5 signed, 32-bit result in one cycle.
// - Op 0x7 adds signed product to result, flags overflow, one cycle.
// - Op 0x8 divides unsigned in 18 cycles, 0x9 signed in 19 cycles.
// - Nine operation codes; 0x6 and 0xA-0xF reserved, never programmed.
// - Each answer returns one 16-bit half chosen by output mode.
// - Mode write takes seven low bits of the source; destination ignored.
// - Mode bits 6:4 are output mode, bits 3:0 operation mode.
// - Output mode 0 returns low half, 1 high half; others reserved.
// - Selecting op 0x0 clears the result register at once.
// - Op 0x1 loads a 16-bit start value into the low half and zeroes the high half.
// - Op 0x2 loads a 32-bit start value into the whole result.
// - Op 0x3 only returns the selected half of the result.
// - One operand send carries both operands; answer has half and flags.
// - Result register holds until a later operation overwrites it.
// - Division leaves quotient in low half and residue in high half.
`timescale 1ns/1ps
module mdc_top
  import mdc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_req_valid,
  input wire mdc_req_t i_req,
  output logic o_ack,
  output mdc_rsp_t o_rsp,
  output logic o_busy
);

  logic [6:0] mode;
  logic [31:0] result;
  logic [31:0] next_result;
  logic [3:0] next_flags;

  // Operands of the running division, kept for checking only
  logic [15:0] div_a;
  logic [15:0] div_b;

  wire [31:0] product;
  wire [31:0] mac_sum;
  wire mac_ovf;
  wire div_done;
  wire [15:0] div_quo;
  wire [15:0] div_res;

  // Request decode; nothing is taken while a division runs
  wire take = i_req_valid && !o_busy;
  wire take_mode = take && (i_req.kind == MDC_REQ_MODE);
  wire take_oper = take && (i_req.kind == MDC_REQ_OPERAND);
  wire take_init = take && (i_req.kind == MDC_REQ_INIT);

  wire [6:0] new_mode = i_req.data_b[MDC_MODE_W-1:0];
  wire [3:0] op = mode[MDC_OP_MSB:MDC_OP_LSB];
  wire [2:0] outm = mode[MDC_OUTM_MSB:MDC_OUTM_LSB];
  wire [6:0] next_mode = take_mode ? new_mode : mode;

  wire is_div = (op == MDC_OP_DIVU) || (op == MDC_OP_DIVS);
  wire div_start = take_oper && is_div;
  wire next_ack = (take && !div_start) || div_done;

  mdc_mac_unit u_mac (
    .i_op_a(i_req.data_a),
    .i_op_b(i_req.data_b),
    .i_signed(op == MDC_OP_MULS),
    .i_acc(result),
    .o_product(product),
    .o_sum(mac_sum),
    .o_overflow(mac_ovf)
  );

  mdc_divider u_div (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_start(div_start),
    .i_signed(op == MDC_OP_DIVS),
    .i_dividend(i_req.data_a),
    .i_divisor(i_req.data_b),
    .o_done(div_done),
    .o_quotient(div_quo),
    .o_residue(div_res)
  );

  // Result register update; reserved codes leave it untouched
  always_comb begin
    next_result = result;
    next_flags = MDC_FLAGS_CLEAR;
    if (div_done) begin
      next_result = {div_res, div_quo};
    end else if (take_mode && (new_mode[MDC_OP_MSB:MDC_OP_LSB] == MDC_OP_CLEAR)) begin
      next_result = 32'h0000_0000;
    end else if (take_oper) begin
      case (op)
        MDC_OP_MULU, MDC_OP_MULS: begin
          next_result = product;
        end
        MDC_OP_MACS: begin
          next_result = mac_sum;
          next_flags[MDC_FLAG_V] = mac_ovf;
        end
        default: begin
          next_result = result;
        end
      endcase
    end else if (take_init && (op == MDC_OP_LOAD16)) begin
      next_result = {16'h0000, i_req.data_b};
    end else if (take_init && (op == MDC_OP_LOAD32)) begin
      next_result = {i_req.data_a, i_req.data_b};
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      mode <= MDC_MODE_RESET;
      result <= 32'h0000_0000;
    end else begin
      mode <= next_mode;
      result <= next_result;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_ack <= 1'b0;
      o_rsp <= '0;
      o_busy <= 1'b0;
    end else begin
      o_ack <= next_ack;
      if (next_ack) begin
        // Reserved output modes fall back to the low half
        o_rsp.data <= mdc_pick_half(next_result, next_mode[MDC_OUTM_MSB:MDC_OUTM_LSB]);
        o_rsp.flags <= next_flags;
      end
      if (div_start) begin
        o_busy <= 1'b1;
      end else if (div_done) begin
        o_busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (div_start) begin
      div_a <= i_req.data_a;
      div_b <= i_req.data_b;
    end
  end

  // Check helpers: cycles spent busy, and whether the standing answer came from an accumulate
  logic [4:0] busy_cycles;
  logic flags_from_mac;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      busy_cycles <= 5'h00;
      flags_from_mac <= 1'b0;
    end else begin
      busy_cycles <= o_busy ? busy_cycles + 5'h01 : 5'h00;
      if (next_ack) begin
        flags_from_mac <= take_oper && (op == MDC_OP_MACS);
      end
    end
  end

  mul_single_cycle_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    take_oper && (op == MDC_OP_MULU)
    |=> o_ack && (result == 32'($past(i_req.data_a)) * 32'($past(i_req.data_b))))
    else $error("unsigned product wrong or late");

  mac_accumulate_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    take_oper && (op == MDC_OP_MACS)
    |=> o_ack && (result == $past(result) + 32'($signed($past(i_req.data_a))) * 32'($signed($past(i_req.data_b))))
        && (o_rsp.flags[MDC_FLAG_V] == $past(mac_ovf)))
    else $error("accumulate result or overflow flag wrong");

  div_latency_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    div_start |=> !o_ack [*8] ##1 !o_ack [*8] ##[1:4] o_ack)
    else $error("division answer outside 17 to 20 cycles");

  div_placement_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    $fell(o_busy) && (op == MDC_OP_DIVU) && (div_b != 16'h0000)
    |-> (32'(result[15:0]) * 32'(div_b) + 32'(result[31:16]) == 32'(div_a)) && (result[31:16] < div_b))
    else $error("quotient and residue misplaced");

  half_select_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    o_ack |-> o_rsp.data == ((outm == MDC_OUTM_HIGH) ? result[31:16] : result[15:0]))
    else $error("returned half does not follow output mode");

  clear_mode_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    take_mode && (i_req.data_b[3:0] == MDC_OP_CLEAR) |=> (result == 32'h0000_0000) && o_ack)
    else $error("clear mode did not zero result");

  init_load_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    take_init && ((op == MDC_OP_LOAD16) || (op == MDC_OP_LOAD32))
    |=> result == (($past(op) == MDC_OP_LOAD32) ? {$past(i_req.data_a), $past(i_req.data_b)}
      : {16'h0000, $past(i_req.data_b)}))
    else $error("start value not loaded");

  read_keeps_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    take_oper && ((op == MDC_OP_READ) || (op == 4'h6) || (op > MDC_OP_DIVS)) |=> $stable(result))
    else $error("read or reserved op changed result");

  busy_hold_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    o_busy && !div_done |=> $stable(mode) && !o_ack)
    else $error("request accepted during division");

  mode_field_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    take_mode |=> mode == $past(i_req.data_b[6:0]))
    else $error("mode register not written from source bits");

  mul_signed_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    take_oper && (op == MDC_OP_MULS)
    |=> o_ack && (result == 32'($signed($past(i_req.data_a))) * 32'($signed($past(i_req.data_b)))))
    else $error("signed product wrong or late");

  ack_single_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    take && !div_start |=> o_ack)
    else $error("request not answered in one cycle");

  div_busy_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    div_start |=> o_busy && !o_ack)
    else $error("division start did not raise busy");

  div_release_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    div_done |=> o_ack && !o_busy)
    else $error("division end not answered");

  busy_bound_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    o_busy |-> busy_cycles < 5'(MDC_DIV_MAX_CYC))
    else $error("division busy for too long");

  div_sign_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    $fell(o_busy) && (op == MDC_OP_DIVS)
    |-> (result[31:16] == 16'h0000) || (result[31] == div_a[15]))
    else $error("signed residue sign does not follow dividend");

  flags_clear_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    o_ack && !flags_from_mac |-> o_rsp.flags == MDC_FLAGS_CLEAR)
    else $error("flags set outside accumulate");

  ack_cause_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    o_ack |-> $past(i_req_valid) || $past(div_done))
    else $error("answer without a request");

  // The reset edge itself may change the answer, so that cycle is left out
  rsp_stands_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    !o_ack && !$past(i_reset) |-> $stable(o_rsp))
    else $error("answer changed without acknowledge");

  result_hold_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    !take && !div_done |=> $stable(result))
    else $error("result changed with no operation");

  mode_hold_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    !take_mode |=> $stable(mode))
    else $error("mode changed without a mode write");

endmodule : mdc_top

// ### verif/mdc_cpu_model.sv
// CPU core model issuing coprocessor instructions to the block
`timescale 1ns/1ps
module mdc_cpu_model
  import mdc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_ack,
  input wire mdc_rsp_t i_rsp,
  input wire logic i_busy,
  output logic o_req_valid,
  output mdc_req_t o_req
);
  initial begin
    o_req_valid = 1'b0;
    o_req = '0;
  end

  // Called at a falling edge; returns at the falling edge where the answer stands
  task automatic issue(input mdc_req_kind_t kind, input logic [15:0] a, input logic [15:0] b,
                       output mdc_rsp_t rsp, output int lat);
    lat = 0;
    while (i_busy !== 1'b0 && lat < 30) begin
      @(negedge i_clock);
      lat++;
    end
    o_req_valid = 1'b1;
    o_req = '{kind, a, b};
    @(negedge i_clock);
    o_req_valid = 1'b0;
    // Released lines show the inverse, never the last request
    o_req = mdc_req_t'(~o_req);
    lat = 1;
    while (i_ack !== 1'b1 && lat < 30) begin
      @(negedge i_clock);
      lat++;
    end
    rsp = i_rsp;
  endtask : issue
endmodule : mdc_cpu_model

// ### verif/testbench.sv
// Self-checking bench for the multiply/divide coprocessor
`timescale 1ns/1ps
module testbench;
  import mdc_pkg::*;

  typedef struct packed {
    mdc_req_kind_t kind;
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] data;
    logic [3:0] flags;
    logic [4:0] lat;
  } mdc_row_t;

  logic i_clock;
  logic i_reset;
  logic req_valid;
  mdc_req_t req;
  logic ack;
  mdc_rsp_t rsp;
  logic busy;
  mdc_rsp_t got;
  int lat;
  int n_fail = 0;
  int checks = 0;

  // Only documented codes are programmed lat 0 marks a division
  mdc_row_t rows [20] = '{
    '{MDC_REQ_MODE, 16'hFFFF, 16'h0004, 16'h0000, 4'h0, 5'h01},
    '{MDC_REQ_OPERAND, 16'hFFFF, 16'hFFFF, 16'h0001, 4'h0, 5'h01},
    '{MDC_REQ_MODE, 16'h0000, 16'h0013, 16'hFFFE, 4'h0, 5'h01},
    '{MDC_REQ_MODE, 16'h0000, 16'h0015, 16'hFFFE, 4'h0, 5'h01},
    '{MDC_REQ_OPERAND, 16'hFFFF, 16'hFFFF, 16'h0000, 4'h0, 5'h01},
    '{MDC_REQ_MODE, 16'h0000, 16'h0000, 16'h0000, 4'h0, 5'h01},
    '{MDC_REQ_MODE, 16'h0000, 16'h0012, 16'h0000, 4'h0, 5'h01},
    '{MDC_REQ_INIT, 16'h7FFF, 16'hFFFF, 16'h7FFF, 4'h0, 5'h01},
    '{MDC_REQ_MODE, 16'h0000, 16'h0017, 16'h7FFF, 4'h0, 5'h01},
    '{MDC_REQ_OPERAND, 16'h0001, 16'h0001, 16'h8000, 4'h4, 5'h01},
    '{MDC_REQ_MODE, 16'h0000, 16'h0001, 16'h0000, 4'h0, 5'h01},
    '{MDC_REQ_INIT, 16'h1234, 16'h5678, 16'h5678, 4'h0, 5'h01},
    '{MDC_REQ_MODE, 16'h0000, 16'h0013, 16'h0000, 4'h0, 5'h01},
    '{MDC_REQ_MODE, 16'h0000, 16'h0008, 16'h5678, 4'h0, 5'h01},
    '{MDC_REQ_OPERAND, 16'h0064, 16'h0007, 16'h000E, 4'h0, 5'h00},
    '{MDC_REQ_MODE, 16'h0000, 16'h0013, 16'h0002, 4'h0, 5'h01},
    '{MDC_REQ_MODE, 16'h0000, 16'h0019, 16'h0002, 4'h0, 5'h01},
    '{MDC_REQ_OPERAND, 16'hFF9C, 16'h0007, 16'hFFFE, 4'h0, 5'h00},
    '{MDC_REQ_MODE, 16'h0000, 16'h0003, 16'hFFF2, 4'h0, 5'h01},
    '{MDC_REQ_OPERAND, 16'h0000, 16'h0000, 16'hFFF2, 4'h0, 5'h01}
  };

  mdc_top dut (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_req_valid(req_valid),
    .i_req(req),
    .o_ack(ack),
    .o_rsp(rsp),
    .o_busy(busy)
  );

  mdc_cpu_model cpu (
    .i_clock(i_clock),
    .i_ack(ack),
    .i_rsp(rsp),
    .i_busy(busy),
    .o_req_valid(req_valid),
    .o_req(req)
  );

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done

  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end

  // Whole run is well under two hundred cycles
  initial begin
    #40000;
    n_fail++;
    test_done();
  end

  initial begin
    i_reset = 1'b1;
    repeat (4) @(negedge i_clock);
    i_reset = 1'b0;
    check("idle", 32'h0, 32'({ack, busy, rsp}));
    for (int i = 0; i < 20; i++) begin
      cpu.issue(rows[i].kind, rows[i].a, rows[i].b, got, lat);
      check("data", rows[i].data, got.data);
      check("flags", rows[i].flags, got.flags);
      if (rows[i].lat == 5'h01)
        check("latency", 1, lat);
      else
        check("div_latency", 1, lat >= MDC_DIV_MIN_CYC && lat <= MDC_DIV_MAX_CYC);
    end
    // A division keeps busy raised until its answer
    cpu.issue(MDC_REQ_MODE, 16'h0000, 16'h0018, got, lat);
    check("div_mode", 16'hFFFE, got.data);
    fork
      cpu.issue(MDC_REQ_OPERAND, 16'hFFFF, 16'h0010, got, lat);
      begin
        repeat (5) @(negedge i_clock);
        check("busy", 1, busy);
      end
    join
    check("div_high", 16'h000F, got.data);
    check("div_latency", 1, lat >= MDC_DIV_MIN_CYC && lat <= MDC_DIV_MAX_CYC);
    cpu.issue(MDC_REQ_MODE, 16'h0000, 16'h0003, got, lat);
    check("div_low", 16'h0FFF, got.data);
    // Reset in the middle of a division drops it and clears the result
    cpu.issue(MDC_REQ_MODE, 16'h0000, 16'h0008, got, lat);
    check("div_mode", 16'h0FFF, got.data);
    fork
      cpu.issue(MDC_REQ_OPERAND, 16'h0100, 16'h0003, got, lat);
      begin
        repeat (4) @(negedge i_clock);
        i_reset = 1'b1;
        @(negedge i_clock);
        i_reset = 1'b0;
        check("reset_mid", 32'h0, 32'({ack, busy, rsp}));
      end
    join
    cpu.issue(MDC_REQ_MODE, 16'h0000, 16'h0013, got, lat);
    check("reset_result", 16'h0000, got.data);
    test_done();
  end
endmodule : testbench
